// ===== hw/pus_pkg.sv
// package for the power-up reset sequencer: constants and carrier types
package pus_pkg;

  localparam int DOMAIN_COUNT = 8;
  localparam int ALWAYS_ON_DOMAIN_IDX = 0;
  localparam logic [7:0] DOMAIN_ON_RESET = 8'h01;

  // oscillator cycles per power-up phase
  localparam logic [11:0] OSC_PHASE_CYCLES = 12'h0408;
  localparam logic [11:0] FUSE_PHASE_CYCLES = 12'h049C;
  localparam logic [11:0] PUMP_PHASE_CYCLES = 12'h02B0;
  localparam logic [11:0] BANK_PHASE_CYCLES = 12'h0269;

  localparam logic [31:0] BOOT_ADDRESS = 32'h0000_0000;

  // glitch filter on the power-on reset pin
  localparam int CLK_PERIOD_NS = 25;
  localparam int POR_FILTER_MIN_NS = 500;
  localparam int POR_FILTER_MAX_NS = 2000;
  // low must persist at least MIN, and is always taken once longer than MAX
  localparam int POR_FILTER_CYCLES_INT = (POR_FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] POR_FILTER_CYCLES = 8'(POR_FILTER_CYCLES_INT);

  // phase sequence, gray coded along the usual path
  typedef enum logic [2:0] {
    PUS_HOLD = 3'b000,
    PUS_OSC = 3'b001,
    PUS_FUSE = 3'b011,
    PUS_PUMP = 3'b010,
    PUS_BANK = 3'b110,
    PUS_RUN = 3'b111
  } pus_phase_t;

  // supply monitor indications
  typedef struct packed {
    logic core_power_good;
    logic io_power_good;
    logic core_out_of_range;
    logic io_low;
  } pus_supply_t;

  // bus access check against domain power
  typedef struct packed {
    logic valid;
    logic [2:0] domain;
  } pus_access_t;

endpackage

// ===== hw/pus_sequencer.sv
// power-up reset sequencer: domain switches, supply reaction, por filter, phases
`timescale 1ns/100ps
`default_nettype none
module pus_sequencer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // supply monitor and external reset
  input wire pus_pkg::pus_supply_t i_supply,
  input wire logic i_low_power_mode,
  input wire logic i_power_on_reset_n,
  // domain configuration after initialisation
  input wire logic i_domain_cfg_valid,
  input wire logic [7:0] i_domain_cfg_on,
  // bus access check
  input wire pus_pkg::pus_access_t i_access,
  // status and control outputs
  output logic o_access_abort,
  output logic [7:0] o_domain_power,
  output logic [7:0] o_domain_reset,
  output logic o_isolate,
  output logic o_pins_hiz,
  output logic o_internal_por,
  output logic o_supply_monitor_en,
  output logic o_cpu_reset,
  output logic [31:0] o_boot_address,
  output pus_pkg::pus_phase_t o_phase
);
  import pus_pkg::*;

  // supply monitor view; indications count only while the monitor is on
  logic monitor_en;
  logic io_low;
  logic core_bad;
  logic core_good;
  logic io_good;
  logic supplies_good;
  logic por_async;
  logic init_done;

  assign monitor_en = ~i_low_power_mode;
  assign io_low = monitor_en & i_supply.io_low;
  assign core_bad = monitor_en & i_supply.core_out_of_range;
  assign core_good = ~monitor_en | i_supply.core_power_good;
  assign io_good = ~monitor_en | i_supply.io_power_good;
  // both must be good, so the supplies may ramp up or down in either order
  assign supplies_good = core_good & io_good;

  // por pin filter: a low counts only once it has stood for the whole span;
  // the span sits at the short end so that no long low can be missed
  // the pin is taken as synchronous; a low shorter than one clock may be lost
  logic [7:0] flt_cnt_r, flt_cnt_nxt;
  logic por_filt_r, por_filt_nxt;
  logic pin_low;

  assign pin_low = ~i_power_on_reset_n;

  always_comb begin
    flt_cnt_nxt = flt_cnt_r;
    por_filt_nxt = por_filt_r;
    if (!pin_low) begin
      // any high sample restarts the count and drops the filtered reset
      flt_cnt_nxt = 8'h00;
      por_filt_nxt = 1'b0;
    end else if (flt_cnt_r < POR_FILTER_CYCLES - 8'h01) begin
      flt_cnt_nxt = flt_cnt_r + 8'h01;
    end else begin
      por_filt_nxt = 1'b1;
    end
  end

  // starts asserted, so a pin that is low through start-up keeps everything held
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flt_cnt_r <= 8'h00;
      por_filt_r <= 1'b1;
    end else begin
      flt_cnt_r <= flt_cnt_nxt;
      por_filt_r <= por_filt_nxt;
    end
  end

  // internal power-on reset: async so the sequencer drops at once;
  // pin filter and monitor both feed it, so any one of them restarts the phases
  assign por_async = ~i_resetn | por_filt_r | io_low | core_bad;

  // phase counter, clocked by the oscillator clock
  // the count reloads at every phase change, so each phase is timed from its start
  pus_phase_t phase_r, phase_nxt;
  logic [11:0] cyc_r, cyc_nxt;
  logic phase_end;

  // length of each counted phase; hold and run are not counted
  function automatic logic [11:0] phase_len(input pus_phase_t p);
    phase_len = 12'h0001;
    unique case (p)
      PUS_OSC: begin
        phase_len = OSC_PHASE_CYCLES;
      end
      PUS_FUSE: begin
        phase_len = FUSE_PHASE_CYCLES;
      end
      PUS_PUMP: begin
        phase_len = PUMP_PHASE_CYCLES;
      end
      PUS_BANK: begin
        phase_len = BANK_PHASE_CYCLES;
      end
      PUS_HOLD, PUS_RUN: begin
        phase_len = 12'h0001;
      end
    endcase
  endfunction

  // the fixed order of the phases; run is the end of the line
  function automatic pus_phase_t phase_after(input pus_phase_t p);
    phase_after = PUS_RUN;
    unique case (p)
      PUS_HOLD: begin
        phase_after = PUS_OSC;
      end
      PUS_OSC: begin
        phase_after = PUS_FUSE;
      end
      PUS_FUSE: begin
        phase_after = PUS_PUMP;
      end
      PUS_PUMP: begin
        phase_after = PUS_BANK;
      end
      PUS_BANK, PUS_RUN: begin
        phase_after = PUS_RUN;
      end
    endcase
  endfunction

  assign phase_end = (cyc_r == phase_len(phase_r) - 12'h001);

  always_comb begin
    phase_nxt = phase_r;
    cyc_nxt = cyc_r;
    unique case (phase_r)
      PUS_HOLD: begin
        cyc_nxt = 12'h000;
        // the por pin is released here, since internal por pins this state
        if (supplies_good) begin
          phase_nxt = phase_after(phase_r);
        end
      end
      PUS_OSC, PUS_FUSE, PUS_PUMP, PUS_BANK: begin
        if (phase_end) begin
          cyc_nxt = 12'h000;
          phase_nxt = phase_after(phase_r);
        end else begin
          cyc_nxt = cyc_r + 12'h001;
        end
      end
      PUS_RUN: begin
        cyc_nxt = 12'h000;
      end
      default: begin
        // an illegal code falls back to hold instead of running on
        phase_nxt = PUS_HOLD;
        cyc_nxt = 12'h000;
      end
    endcase
  end

  // the whole sequence restarts from hold on any internal power-on reset
  always_ff @(posedge i_clk or posedge por_async) begin
    if (por_async) begin
      phase_r <= PUS_HOLD;
      cyc_r <= 12'h000;
    end else begin
      phase_r <= phase_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  // domain power state, switchable once per power-up
  logic [7:0] dom_r, dom_nxt;
  logic cfg_used_r, cfg_used_nxt;
  logic cfg_take;
  logic [7:0] cfg_on;

  assign init_done = (phase_r == PUS_RUN);
  // the always-on domain is forced on whatever the request says
  assign cfg_on = i_domain_cfg_on | DOMAIN_ON_RESET;
  // a request before the sequence ends, or a second one, is dropped silently
  assign cfg_take = init_done & ~cfg_used_r & i_domain_cfg_valid;

  always_comb begin
    dom_nxt = dom_r;
    cfg_used_nxt = cfg_used_r;
    if (cfg_take) begin
      dom_nxt = cfg_on;
      cfg_used_nxt = 1'b1;
    end
    dom_nxt[ALWAYS_ON_DOMAIN_IDX] = 1'b1;
  end

  // the domain state is cleared by every internal por, so a single switch stays single
  // only until the next internal power-on reset; switchable domains start powered
  always_ff @(posedge i_clk or posedge por_async) begin
    if (por_async) begin
      dom_r <= 8'hFF;
      cfg_used_r <= 1'b0;
    end else begin
      dom_r <= dom_nxt;
      cfg_used_r <= cfg_used_nxt;
    end
  end

  // an unpowered domain is held in reset so that it returns with defaults;
  // built from next values so that it lines up with the power bits
  // every domain is held while the cpu is, so nothing starts half powered
  logic [7:0] dom_rst_r, dom_rst_nxt;

  always_comb begin
    dom_rst_nxt = ~dom_nxt;
    if (phase_nxt != PUS_RUN) begin
      dom_rst_nxt = 8'hFF;
    end
  end

  always_ff @(posedge i_clk or posedge por_async) begin
    if (por_async) begin
      dom_rst_r <= 8'hFF;
    end else begin
      dom_rst_r <= dom_rst_nxt;
    end
  end

  // cpu reset from the next phase, so it falls on the edge that enters run
  logic cpu_rst_r, cpu_rst_nxt;

  always_comb begin
    cpu_rst_nxt = 1'b1;
    if (phase_nxt == PUS_RUN) begin
      cpu_rst_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge por_async) begin
    if (por_async) begin
      cpu_rst_r <= 1'b1;
    end else begin
      cpu_rst_r <= cpu_rst_nxt;
    end
  end

  // abort answer, one cycle after the access
  logic abort_r, abort_nxt;

  always_comb begin
    abort_nxt = 1'b0;
    if (i_access.valid && !dom_r[i_access.domain]) begin
      abort_nxt = 1'b1;
    end
  end

  // cleared by the block reset alone, so an access during a power-on gets its answer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= abort_nxt;
    end
  end

  // isolation, tri-state and reset follow the monitor with no clock edge
  assign o_isolate = ~supplies_good;
  assign o_pins_hiz = core_bad;
  assign o_internal_por = por_async;
  assign o_supply_monitor_en = monitor_en;
  // registered outputs
  assign o_access_abort = abort_r;
  assign o_domain_power = dom_r;
  assign o_domain_reset = dom_rst_r;
  assign o_cpu_reset = cpu_rst_r;
  // the first fetch after release comes from this fixed address
  assign o_boot_address = BOOT_ADDRESS;
  assign o_phase = phase_r;

endmodule // pus_sequencer
`default_nettype wire

// ===== verification/pus_sequencer_asserts.sv
// checker: port-level assertions for the power-up reset sequencer
`timescale 1ns/100ps
`default_nettype none
module pus_sequencer_asserts (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_low_power_mode,
  input wire pus_pkg::pus_supply_t i_supply,
  input wire pus_pkg::pus_access_t i_access,
  input wire logic o_access_abort,
  input wire logic o_isolate,
  input wire logic o_pins_hiz,
  input wire logic o_internal_por,
  input wire logic o_cpu_reset,
  input wire logic [7:0] o_domain_power,
  input wire logic [31:0] o_boot_address,
  input wire pus_pkg::pus_phase_t o_phase
);
  import pus_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // indications only count while the monitor is on
  wire logic mon = !i_low_power_mode;
  a_dead_domain: assert property (i_access.valid &&
    !o_domain_power[i_access.domain] |=> o_access_abort) else $error("abort missing");
  a_isolate_pg: assert property (mon &&
    !(i_supply.core_power_good && i_supply.io_power_good) |-> o_isolate) else $error("no iso");
  a_io_low_por: assert property (mon && i_supply.io_low |-> o_internal_por)
    else $error("io low por");
  a_core_hiz: assert property (mon && i_supply.core_out_of_range |->
    o_pins_hiz && o_internal_por) else $error("core hiz");
  a_always_on: assert property (o_domain_power[0]) else $error("aon off");
  a_boot_zero: assert property (!o_cpu_reset |-> o_boot_address == 32'h0000_0000)
    else $error("boot addr");
  a_cpu_release: assert property ($fell(o_cpu_reset) |->
    $past(o_phase) == PUS_BANK && o_phase == PUS_RUN) else $error("early release");
  a_start_gate: assert property ($changed(o_phase) && o_phase == PUS_OSC |->
    $past(o_phase) == PUS_HOLD && !$past(o_internal_por)) else $error("bad start");
endmodule // pus_sequencer_asserts
bind pus_sequencer pus_sequencer_asserts u_chk (.i_clk, .i_resetn, .i_low_power_mode,
  .i_supply, .i_access, .o_access_abort, .o_isolate, .o_pins_hiz, .o_internal_por,
  .o_cpu_reset, .o_domain_power, .o_boot_address, .o_phase);
`default_nettype wire

// ===== verification/pus_supervisor.sv
// supervisor model driving the power-on reset pin
`timescale 1ns/100ps
`default_nettype none
module pus_supervisor (
  input wire logic i_clk,
  input wire logic i_supply_ok,
  input wire logic i_pulse_req,
  input wire logic [7:0] i_pulse_len,
  output logic o_power_on_reset_n
);
  logic [7:0] left_r = 8'h00;
  // commanded low pulse in whole cycles, changed just after the edge
  always @(posedge i_clk) begin
    if (i_pulse_req)
      left_r <= i_pulse_len;
    else if (left_r != 8'h00)
      left_r <= left_r - 8'h01;
  end
  assign o_power_on_reset_n = i_supply_ok && left_r == 8'h00;
endmodule // pus_supervisor
`default_nettype wire

// ===== verification/tb.sv
// testbench for the power-up reset sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb;
  import pus_pkg::*;
  logic i_clk = 0, i_resetn = 0, i_low_power_mode = 0, i_domain_cfg_valid = 0;
  logic pulse_req = 0, hit, i_power_on_reset_n;
  logic [7:0] i_domain_cfg_on = 8'h00, pulse_len = 8'h00, o_domain_power, o_domain_reset;
  pus_supply_t i_supply = 4'b1100;
  pus_access_t i_access = 4'h0;
  logic o_access_abort, o_isolate, o_pins_hiz, o_internal_por, o_supply_monitor_en, o_cpu_reset;
  logic [31:0] o_boot_address;
  pus_phase_t o_phase;
  int bad_count = 0, checks = 0, n;
  pus_sequencer u_pus_sequencer (.i_clk, .i_resetn, .i_supply, .i_low_power_mode,
    .i_power_on_reset_n, .i_domain_cfg_valid, .i_domain_cfg_on, .i_access, .o_access_abort,
    .o_domain_power, .o_domain_reset, .o_isolate, .o_pins_hiz, .o_internal_por,
    .o_supply_monitor_en, .o_cpu_reset, .o_boot_address, .o_phase);
  pus_supervisor u_pus_supervisor (.i_clk, .i_supply_ok(i_supply == 4'b1100),
    .i_pulse_req(pulse_req), .i_pulse_len(pulse_len), .o_power_on_reset_n(i_power_on_reset_n));
  initial forever #12.5 i_clk = ~i_clk;
  task automatic tick(int k);
    repeat (k) @(negedge i_clk);
  endtask
  // counts cycles until the phase shows up, bounded so a stall cannot hang
  task automatic wait_ph(pus_phase_t p);
    n = 0;
    while (o_phase !== p && n < 4000) begin
      tick(1);
      n++;
    end
  endtask
  // no module clock runs in the bench, so every domain except the always-on one may be switched off
  task automatic cfg(logic [7:0] v);
    i_domain_cfg_on = v;
    i_domain_cfg_valid = 1;
    tick(1);
    i_domain_cfg_valid = 0;
    tick(1);
  endtask
  task automatic pulse(logic [7:0] k);
    pulse_len = k;
    pulse_req = 1;
    tick(1);
    pulse_req = 0;
    hit = 0;
    repeat (30) begin
      tick(1);
      hit = hit | o_internal_por;
    end
  endtask
  task automatic t_boot;
    wait_ph(PUS_OSC);
    `CHK("dom_rst0", 8'hFF, o_domain_reset)
    wait_ph(PUS_FUSE);
    `CHK("osc", 1032, n)
    wait_ph(PUS_PUMP);
    `CHK("fuse", 1180, n)
    wait_ph(PUS_BANK);
    `CHK("pump", 688, n)
    wait_ph(PUS_RUN);
    `CHK("bank", 617, n)
    `CHK("cpu", 1'b0, o_cpu_reset)
    `CHK("boot", 32'h0000_0000, o_boot_address)
    $display("t_boot done");
  endtask
  task automatic t_domains;
    cfg(8'h00);
    `CHK("dom", 8'h01, o_domain_power)
    `CHK("dom_rst", 8'hFE, o_domain_reset)
    cfg(8'hFF);
    `CHK("dom2", 8'h01, o_domain_power)
    i_access = {1'b1, 3'd3};
    tick(1);
    i_access = {1'b1, 3'd0};
    `CHK("abort", 1'b1, o_access_abort)
    tick(1);
    i_access = 4'h0;
    `CHK("noabort", 1'b0, o_access_abort)
    $display("t_domains done");
  endtask
  task automatic t_glitch;
    pulse(8'd19);
    `CHK("short", 1'b0, hit)
    pulse(8'd21);
    `CHK("long", 1'b1, hit)
    `CHK("cpu_rst", 1'b1, o_cpu_reset)
    $display("t_glitch done");
  endtask
  task automatic t_supply;
    i_supply = 4'b0100;
    tick(25);
    `CHK("iso", 1'b1, o_isolate)
    `CHK("hold", PUS_HOLD, o_phase)
    i_supply = 4'b1101;
    tick(1);
    `CHK("io_por", 1'b1, o_internal_por)
    i_supply = 4'b1110;
    #3;
    `CHK("hiz", 1'b1, o_pins_hiz)
    i_low_power_mode = 1;
    #3;
    `CHK("lp_hiz", 1'b0, o_pins_hiz)
    `CHK("mon", 1'b0, o_supply_monitor_en)
    $display("t_supply done");
  endtask
  task automatic close_out;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    tick(20);
    i_resetn = 1;
    t_boot;
    t_domains;
    t_glitch;
    t_supply;
    close_out;
  end
  initial begin
    tick(20000);
    bad_count++;
    close_out;
  end
endmodule // tb
`default_nettype wire
